// [hw/bmf_pkg.sv]
package bmf_pkg;
    // Register indices on the register port.
    localparam logic [2:0] REG_MODE = 3'h1;
    localparam logic [2:0] REG_LINK_PWR = 3'h2;
    localparam logic [2:0] REG_CAP_FULL = 3'h3;
    localparam logic [2:0] REG_CAP_EMPTY = 3'h4;
    localparam logic [2:0] REG_SYNC = 3'h5;
    localparam logic [2:0] REG_CID_LO = 3'h6;
    localparam logic [2:0] REG_CID_HI = 3'h7;
    // Reset values.
    localparam logic [15:0] MODE_RST = 16'h0000;
    localparam logic [15:0] LINK_PWR_RST = 16'h0000;
    localparam logic [15:0] SYNC_RST = 16'h0000;
    localparam logic [15:0] CID_RST = 16'h0000;
    // Field positions.
    localparam int MODE_TEST_BIT = 0;
    localparam int MODE_INHIBIT_BIT = 1;
    localparam int PWR_BURST_BIT = 9;
    localparam int SYNC_EN_BIT = 0;
    localparam int SYNC_SEL_LSB = 1;
    localparam int SYNC_OFS_LSB = 3;
    localparam int SYNC_PASS_BIT = 8;
    localparam int NUM_RX = 9;
    localparam int NUM_CAP = 15;
    // Muon geometry.
    localparam int NUM_IN = 6;
    localparam int NUM_OUT = 3;
    localparam int MU_W = 40;
    localparam int LINK_W = 20;
    localparam int FRAME_W = 120;
    localparam int QUAL_W = 8;
    localparam int BX_W = 5;
    // Test pattern burst length in words.
    localparam logic [3:0] BURST_WORDS = 4'h8;
endpackage

// [hw/bmf_framer.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Frame FIFO
// ----------------------------------------------------------------
module bmf_fifo #(
    parameter int WIDTH = 120,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // Full and empty come straight from the fill count.
    assign in_ready = (count < (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];

    // Pointers and count move on push and pop.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Storage is written only on push.
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule

// ----------------------------------------------------------------
// Output framer
// ----------------------------------------------------------------
module bmf_framer
    import bmf_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ccb_reset,
    input wire logic bunch_zero_marker,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    input wire logic muon_valid,
    output logic muon_ready,
    input wire logic [NUM_IN*MU_W-1:0] trig_muons,
    input wire logic [NUM_IN*MU_W-1:0] test_muons,
    input wire logic [NUM_IN*QUAL_W-1:0] muon_quality,
    output logic test_rd,
    input wire logic [NUM_CAP-1:0] cap_full,
    input wire logic [NUM_CAP-1:0] cap_empty,
    output logic [NUM_RX-1:0] rx_power_up,
    output logic rx_out_en,
    output logic link_valid,
    input wire logic link_ready,
    output logic [FRAME_W-1:0] link_data
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [15:0] mode_and_inhibit_control;
    logic [15:0] link_power_control;
    logic [15:0] sync_check_control;
    logic [15:0] chamber_id_low;
    logic [15:0] chamber_id_high;
    logic [15:0] rd_mux;

    // Software writes; reserved bits of the mode and power registers stay zero.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mode_and_inhibit_control <= MODE_RST;
            link_power_control <= LINK_PWR_RST;
            sync_check_control <= SYNC_RST;
            chamber_id_low <= CID_RST;
            chamber_id_high <= CID_RST;
        end else if (reg_wr) begin
            unique case (reg_addr)
                REG_MODE: mode_and_inhibit_control <= {14'h0000, reg_wdata[1:0]};
                REG_LINK_PWR: link_power_control <= {6'h00, reg_wdata[9:0]};
                REG_SYNC: sync_check_control <= {7'h00, reg_wdata[8:0]};
                REG_CID_LO: chamber_id_low <= reg_wdata;
                REG_CID_HI: chamber_id_high <= {8'h00, reg_wdata[7:0]};
                default: ;
            endcase
        end
    end

    // Read selection; bit 15 of both flag registers reads zero.
    always_comb begin
        unique case (reg_addr)
            REG_MODE: rd_mux = mode_and_inhibit_control;
            REG_LINK_PWR: rd_mux = link_power_control;
            REG_CAP_FULL: rd_mux = {1'b0, cap_full};
            REG_CAP_EMPTY: rd_mux = {1'b0, cap_empty};
            REG_SYNC: rd_mux = sync_check_control;
            REG_CID_LO: rd_mux = chamber_id_low;
            REG_CID_HI: rd_mux = chamber_id_high;
            default: rd_mux = 16'h0000;
        endcase
    end

    // Read data is registered on a read strobe.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Receiver control
    // ------------------------------------------------------------
    wire inhibit = mode_and_inhibit_control[MODE_INHIBIT_BIT];
    assign rx_out_en = inhibit;
    assign rx_power_up = inhibit ? link_power_control[NUM_RX-1:0] : '0;

    // ------------------------------------------------------------
    // Test pattern burst
    // ------------------------------------------------------------
    logic [3:0] burst_left;
    wire burst_go = bunch_zero_marker && link_power_control[PWR_BURST_BIT];

    // Each bunch zero with the burst bit set reads eight test words.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            burst_left <= 4'h0;
        end else if (burst_go) begin
            burst_left <= BURST_WORDS;
        end else if (burst_left != 4'h0 && muon_ready) begin
            burst_left <= burst_left - 4'h1;
        end
    end
    assign test_rd = (burst_left != 4'h0) && muon_ready;

    // ------------------------------------------------------------
    // Source select and stage one
    // ------------------------------------------------------------
    wire test_mode = mode_and_inhibit_control[MODE_TEST_BIT];
    wire [NUM_IN*MU_W-1:0] src = test_mode ? test_muons : trig_muons;
    wire src_valid = test_mode ? test_rd : muon_valid;
    wire [31:0] cid_all = {chamber_id_high, chamber_id_low};
    logic stall;
    logic s1_valid;
    logic [NUM_IN*MU_W-1:0] s1_mu;
    logic [NUM_IN*QUAL_W-1:0] s1_q;
    logic [NUM_IN*4-1:0] s1_cid;

    assign muon_ready = !stall;

    // Inputs are captured with their chamber ids; each slot takes its own four id bits.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s1_valid <= 1'b0;
            s1_mu <= '0;
            s1_q <= '0;
            s1_cid <= '0;
        end else if (!stall) begin
            s1_valid <= src_valid;
            s1_mu <= src;
            s1_q <= muon_quality;
            s1_cid <= cid_all[NUM_IN*4-1:0];
        end
    end

    // ------------------------------------------------------------
    // Ranking, stage two
    // ------------------------------------------------------------
    // True when muon a outranks muon b; ties go to the lower slot.
    function automatic logic beats(input logic [QUAL_W-1:0] qa, input logic [QUAL_W-1:0] qb,
                                   input int a, input int b);
        beats = (qa > qb) || (qa == qb && a < b);
    endfunction

    logic [NUM_OUT*(MU_W+4)-1:0] next_best;
    always_comb begin
        int rank;
        rank = 0;
        next_best = '0;
        for (int i = 0; i < NUM_IN; i++) begin
            rank = 0;
            for (int j = 0; j < NUM_IN; j++) begin
                if (j != i && beats(s1_q[j*QUAL_W +: QUAL_W], s1_q[i*QUAL_W +: QUAL_W], j, i)) begin
                    rank = rank + 1;
                end
            end
            if (rank < NUM_OUT) begin
                next_best[rank*(MU_W+4) +: MU_W+4] = {s1_cid[i*4 +: 4], s1_mu[i*MU_W +: MU_W]};
            end
        end
    end

    logic s2_valid;
    logic [NUM_OUT*(MU_W+4)-1:0] s2_best;

    // Second clock holds the ranked result.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s2_valid <= 1'b0;
            s2_best <= '0;
        end else if (!stall) begin
            s2_valid <= s1_valid;
            s2_best <= next_best;
        end
    end

    // ------------------------------------------------------------
    // Bunch crossing synchronization
    // ------------------------------------------------------------
    logic [BX_W-1:0] bx_count;
    logic sync_on;

    // Preset on the clock board reset, run from the clock after bunch zero.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bx_count <= '0;
            sync_on <= 1'b0;
        end else if (ccb_reset) begin
            bx_count <= sync_check_control[SYNC_OFS_LSB +: BX_W];
            sync_on <= 1'b0;
        end else begin
            if (bunch_zero_marker) begin
                sync_on <= 1'b1;
            end
            if (sync_on) begin
                bx_count <= bx_count + 1'b1;
            end
        end
    end

    // Input muon word B: bit 0 acc, 1-7 group, 8-9 match, 10-13 status,
    // 14-18 crossing number, 19 sync error.
    function automatic logic [BX_W-1:0] mu_bx(input logic [MU_W+3:0] m);
        mu_bx = m[LINK_W+14 +: BX_W];
    endfunction

    wire [1:0] sync_sel = sync_check_control[SYNC_SEL_LSB +: 2];
    wire [MU_W+3:0] best1 = s2_best[0 +: MU_W+4];
    wire [MU_W+3:0] best2 = s2_best[MU_W+4 +: MU_W+4];
    wire [MU_W+3:0] best3 = s2_best[2*(MU_W+4) +: MU_W+4];
    logic [BX_W-1:0] cmp_bx;
    always_comb begin
        unique case (sync_sel)
            2'h0: cmp_bx = mu_bx(best1);
            2'h1: cmp_bx = mu_bx(best2);
            2'h2: cmp_bx = mu_bx(best3);
            default: cmp_bx = bx_count;
        endcase
    end
    wire int_err = sync_check_control[SYNC_EN_BIT] && sync_on
                   && (cmp_bx != bx_count);
    wire first_err = best1[MU_W-1];
    wire sync_error_bit = sync_check_control[SYNC_PASS_BIT] ? first_err
                          : (first_err | int_err);

    // ------------------------------------------------------------
    // Link word assembly
    // ------------------------------------------------------------
    // Second link word: acc, group, chamber id, match, status, two extra bits.
    function automatic logic [LINK_W-1:0] word_b(input logic [MU_W+3:0] m, input logic [1:0] top);
        word_b = {top, m[LINK_W+10 +: 4], m[LINK_W+8 +: 2], m[MU_W +: 4], m[LINK_W +: 8]};
    endfunction

    wire [BX_W-1:0] bx1 = mu_bx(best1);
    wire [FRAME_W-1:0] frame = {
        word_b(best3, {sync_error_bit, bx1[4]}), best3[LINK_W-1:0],
        word_b(best2, bx1[3:2]), best2[LINK_W-1:0],
        word_b(best1, bx1[1:0]), best1[LINK_W-1:0]
    };

    // ------------------------------------------------------------
    // Output buffer
    // ------------------------------------------------------------
    logic fifo_in_ready;
    assign stall = s2_valid && !fifo_in_ready;

    bmf_fifo #(
        .WIDTH(FRAME_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_valid(s2_valid),
        .in_ready(fifo_in_ready),
        .in_data(frame),
        .out_valid(link_valid),
        .out_ready(link_ready),
        .out_data(link_data)
    );
endmodule

`default_nettype wire

// [testbench/bmf_framer_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// Port checker
// ----
module bmf_framer_checker
    import bmf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic bunch_zero_marker,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic muon_ready,
    input wire logic test_rd,
    input wire logic [NUM_CAP-1:0] cap_full,
    input wire logic [NUM_RX-1:0] rx_power_up,
    input wire logic rx_out_en,
    input wire logic link_valid,
    input wire logic link_ready,
    input wire logic [FRAME_W-1:0] link_data
);
    logic [1:0] mode_q;
    logic [9:0] pwr_q;
    logic [3:0] bz_cnt;
    // Shadow the fields that steer the receiver pins and the burst.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mode_q <= 2'h0;
            pwr_q <= 10'h000;
        end else if (reg_wr && reg_addr == REG_MODE) begin
            mode_q <= reg_wdata[1:0];
        end else if (reg_wr && reg_addr == REG_LINK_PWR) begin
            pwr_q <= reg_wdata[9:0];
        end
    end
    // Count test words taken since the last bunch zero.
    always_ff @(posedge clk_sys) begin
        if (!rst_n || bunch_zero_marker) begin
            bz_cnt <= 4'h0;
        end else if (test_rd && bz_cnt != 4'hf) begin
            bz_cnt <= bz_cnt + 4'h1;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    rx_power_a:
        assert property (rx_power_up == (mode_q[1] ? pwr_q[8:0] : 9'h000))
        else $error("receiver power pins wrong");
    rx_enable_a:
        assert property (rx_out_en == mode_q[1])
        else $error("receiver output enable wrong");
    full_read_a:
        assert property (reg_rd && reg_addr == REG_CAP_FULL |=> reg_rdata == {1'b0, $past(cap_full)})
        else $error("full flags read wrong");
    mode_read_a:
        assert property (reg_rd && reg_addr == REG_MODE |=> reg_rdata == {14'h0000, $past(mode_q)})
        else $error("mode register read wrong");
    burst_len_a:
        assert property (test_rd && !bunch_zero_marker |-> pwr_q[9] && bz_cnt < 4'h8)
        else $error("test burst too long or not enabled");
    frame_hold_a:
        assert property (link_valid && !link_ready |=> link_valid && $stable(link_data))
        else $error("link frame dropped while stalled");
    stall_full_a:
        assert property (!muon_ready |-> link_valid)
        else $error("input stalled with empty output");
    reset_state_a:
        assert property ($rose(rst_n) |-> !link_valid && muon_ready && !test_rd && reg_rdata == 16'h0000)
        else $error("outputs not in reset state");
endmodule
bind bmf_framer bmf_framer_checker i_chk (.clk_sys, .rst_n, .bunch_zero_marker, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .muon_ready, .test_rd, .cap_full, .rx_power_up,
    .rx_out_en, .link_valid, .link_ready, .link_data);
`default_nettype wire

// [testbench/bmf_sink.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// Downstream link sink
// ----
module bmf_sink (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic link_valid,
    input wire logic [119:0] link_data,
    output logic link_ready,
    output logic got,
    output logic [119:0] got_data
);
    logic [1:0] ph;
    // Take a frame every cycle, or one cycle in four when slow.
    always_ff @(posedge clk_sys) begin
        ph <= rst_n ? ph + 2'h1 : 2'h0;
        link_ready <= rst_n && (!slow || ph == 2'h3);
        got <= rst_n && link_valid && link_ready;
        got_data <= link_data;
    end
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// Testbench
// ----
module tb_top
    import bmf_pkg::*;
;
    localparam logic [15:0] MASK [8] = '{16'h0, 16'h3, 16'h3ff, 16'h0, 16'h0, 16'h1ff, 16'hffff,
        16'h00ff};
    localparam logic [15:0] SYNCW [6] = '{16'h59, 16'h5b, 16'h5d, 16'h5f, 16'h58, 16'h159};
    localparam logic [5:0] IE = 6'h06;
    logic clk_sys = 1'b0, rst_n = 1'b0, ccb_reset = 1'b0, bunch_zero_marker = 1'b0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, muon_valid = 1'b0, slow = 1'b0;
    logic muon_ready, test_rd, rx_out_en, link_valid, link_ready, got;
    logic [2:0] reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0, reg_rdata, w;
    logic [239:0] trig_muons = '0, test_muons = '0;
    logic [47:0] muon_quality = '0;
    logic [14:0] cap_full = '0, cap_empty = '0;
    logic [8:0] rx_power_up;
    logic [119:0] link_data, got_data;
    logic [15:0] mdl [8] = '{default: 16'h0};
    logic [119:0] expq [$];
    int err_total = 0, check_count = 0, cyc = 0, nrd = 0, stalls = 0;
    int seed = 32'h0732;
    // Design and far-side sink.
    bmf_framer i_dut (.clk_sys, .rst_n, .ccb_reset, .bunch_zero_marker, .reg_wr, .reg_rd,
        .reg_addr, .reg_wdata, .reg_rdata, .muon_valid, .muon_ready, .trig_muons, .test_muons,
        .muon_quality, .test_rd, .cap_full, .cap_empty, .rx_power_up, .rx_out_en, .link_valid,
        .link_ready, .link_data);
    bmf_sink i_sink (.clk_sys, .rst_n, .slow, .link_valid, .link_data, .link_ready, .got,
        .got_data);
    // Compare, close and drive.
    task automatic chk(input logic [119:0] seen, input logic [119:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        if (err_total == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        mdl[a] = d & MASK[a];
    endtask
    task automatic rd(input logic [2:0] a);
        cap_full = 15'($random(seed));
        cap_empty = 15'($random(seed));
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        chk(reg_rdata, a == 3 ? {1'b0, cap_full} : a == 4 ? {1'b0, cap_empty} : mdl[a], "reg");
    endtask
    task automatic chk_rx();
        chk({rx_out_en, rx_power_up}, {mdl[1][1], mdl[1][1] ? mdl[2][8:0] : 9'h0}, "rx");
    endtask
    function automatic logic [239:0] rnd_mu(input int bxv);
        logic [239:0] m;
        for (int k = 0; k < 6; k++) begin
            m[k*40+:40] = {8'($random(seed)), $random(seed)};
            if (bxv >= 0) m[k*40+34+:5] = bxv[4:0];
        end
        return m;
    endfunction
    // Reference frame: three best ranks, lower index wins ties.
    function automatic logic [119:0] frm(logic [239:0] m, logic [47:0] q, logic ie);
        logic [119:0] f;
        logic [39:0] u, u0;
        logic [5:0] used;
        int b;
        used = '0;
        for (int s = 0; s < 3; s++) begin
            b = -1;
            for (int k = 0; k < 6; k++) begin
                if (!used[k] && (b < 0 || q[k*8+:8] > q[b*8+:8])) b = k;
            end
            used[b] = 1'b1;
            u = m[b*40+:40];
            if (s == 0) u0 = u;
            f[s*40+:20] = u[19:0];
            f[s*40+20+:20] = {2'b00, u[33:28], mdl[6+b/4][(b%4)*4+:4], u[27:20]};
        end
        f[39:38] = u0[35:34];
        f[79:78] = u0[37:36];
        f[119:118] = {u0[39] | ie, u0[38]};
        return f;
    endfunction
    task automatic send(input logic ie, input int bxv);
        trig_muons = rnd_mu(bxv);
        muon_quality = {$random(seed), 16'($random(seed))};
        muon_valid = 1'b1;
        #4;
        while (!muon_ready) begin
            stalls++;
            @(negedge clk_sys);
            #4;
        end
        expq.push_back(frm(trig_muons, muon_quality, ie));
        @(negedge clk_sys);
    endtask
    // Clock and hang limit.
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            wrap_up();
        end
    end
    // Every frame the sink takes must match the oldest expected one.
    always @(negedge clk_sys) begin
        if (got) begin
            if (expq.size() == 0) chk(1, 0, "extra frame");
            else chk(got_data, expq.pop_front(), "frame");
        end
    end
    // Registers, a full buffer, sync error cases, then a test burst.
    initial begin
        repeat (5) @(negedge clk_sys);
        rst_n = 1'b1;
        for (int r = 0; r < 3; r++) begin
            for (int a = 0; a < 8; a++) rd(3'(a));
            for (int a = 0; a < 8; a++) begin
                w = 16'($random(seed));
                if (a == 1) w[1:0] = {r[0], 1'b0};
                if (a == 2) w[9] = 1'b0;
                wr(3'(a), w);
            end
            chk_rx();
        end
        wr(REG_MODE, 16'h0002);
        wr(REG_SYNC, 16'h0000);
        slow = 1'b1;
        for (int i = 0; i < 40; i++) send(1'b0, -1);
        muon_valid = 1'b0;
        chk(stalls > 0, 1, "stall");
        slow = 1'b0;
        while (expq.size() != 0) @(negedge clk_sys);
        for (int i = 0; i < 6; i++) begin
            wr(REG_SYNC, SYNCW[i]);
            ccb_reset = 1'b1;
            @(negedge clk_sys);
            ccb_reset = 1'b0;
            bunch_zero_marker = 1'b1;
            @(negedge clk_sys);
            bunch_zero_marker = 1'b0;
            send(IE[i], i == 0 ? 13 : 27);
            muon_valid = 1'b0;
            while (expq.size() != 0) @(negedge clk_sys);
        end
        wr(REG_MODE, 16'h0001);
        wr(REG_LINK_PWR, 16'h0200);
        chk_rx();
        for (int i = 0; i < 24; i++) begin
            bunch_zero_marker = (i == 0);
            test_muons = rnd_mu(-1);
            #4;
            if (test_rd) begin
                expq.push_back(frm(test_muons, muon_quality, 1'b0));
                nrd++;
            end
            @(negedge clk_sys);
        end
        chk(nrd, 8, "burst");
        while (expq.size() != 0) @(negedge clk_sys);
        wrap_up();
    end
endmodule
`default_nettype wire
